// ### design/sdt_cfg.svh
// constants for the display frame timing generator
`ifndef SDT_CFG_SVH
`define SDT_CFG_SVH
`define SDT_ADDR_CTRL 12'h000
`define SDT_ADDR_CPP 12'h004
`define SDT_ADDR_HTOTAL 12'h008
`define SDT_ADDR_HSW 12'h00c
`define SDT_ADDR_HBLANK 12'h010
`define SDT_ADDR_HACT 12'h014
`define SDT_ADDR_VTOTAL 12'h018
`define SDT_ADDR_VSW 12'h01c
`define SDT_ADDR_VBLANK 12'h020
`define SDT_ADDR_VACT 12'h024
`define SDT_ADDR_STATUS 12'h028
`define SDT_ADDR_PIXEL 12'h02c
`define SDT_CTRL_EN_BIT 0
`define SDT_RST_CPP 4'h1
`define SDT_RST_HTOTAL 12'h020
`define SDT_RST_HSW 13'h0004
`define SDT_RST_HBLANK 12'h004
`define SDT_RST_HACT 12'h010
`define SDT_RST_VTOTAL 12'h010
`define SDT_RST_VSW 13'h0002
`define SDT_RST_VBLANK 12'h002
`define SDT_RST_VACT 12'h008
`define SDT_FIFO_DEPTH 16
`define SDT_PIX_W 24
`endif

// ### design/sdt_pkg.sv
// types for the display frame timing generator
package sdt_pkg;
	typedef enum logic [1:0] {
		SDT_IDLE,
		SDT_RUN
	} sdt_state_type;
endpackage

// ### design/sdt_stream_if.sv
// pixel stream carrier between write side and fifo
`timescale 1ns/1ps
interface sdt_stream_if;
	logic valid;
	logic ready;
	logic [23:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ### design/sdt_fifo.sv
// parameterised fifo with valid/ready on both sides
`timescale 1ns/1ps
module sdt_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// fill side
	sdt_stream_if.snk wr,
	// drain side
	output logic rd_valid,
	output logic [WIDTH-1:0] rd_data,
	input wire logic rd_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic do_wr;
	logic do_rd;
	assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
	assign rd_valid = (cnt_q != '0);
	assign do_wr = wr.valid && wr.ready;
	assign do_rd = rd_valid && rd_ready;
	assign rd_data = mem[rp_q];
	always_ff @(posedge pclk) begin
		if (do_wr)
			mem[wp_q] <= wr.data;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (do_wr)
				wp_q <= wp_q + 1'b1;
			if (do_rd)
				rp_q <= rp_q + 1'b1;
			if (do_wr && !do_rd)
				cnt_q <= cnt_q + 1'b1;
			else if (do_rd && !do_wr)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule // sdt_fifo

// ### design/sdt_timing.sv
// display frame timing generator with apb registers and pixel fifo
// Behaviour
// - each pixel spans clocks_per_pixel interface clocks
// - line counter counts line total incl blanking
// - line sync width in half-clock steps
// - leading_h_blank clocks before first active word
// - trailing blank fills rest of line
// - frame counts lines incl blanking
// - frame sync width in half-clock steps
// - leading_v_blank lines start each frame
// - trailing vertical blank fills rest of frame
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "sdt_cfg.svh"
module sdt_timing (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// display side
	output logic line_sync,
	output logic line_sync_half,
	output logic frame_sync,
	output logic frame_sync_half,
	output logic pix_valid,
	output logic [23:0] pix_data,
	output logic pix_comp_first
);
	sdt_stream_if fill ();
	sdt_pkg::sdt_state_type state_q;
	logic en_q;
	logic [3:0] cpp_q;
	logic [11:0] htot_q, hblk_q, hact_q, vtot_q, vblk_q, vact_q;
	logic [12:0] hsw_q, vsw_q;
	logic [3:0] comp_q;
	logic [11:0] hcnt_q, vcnt_q;
	logic [12:0] vsc_q;
	logic f_valid;
	logic [23:0] f_data;
	logic f_ready;
	logic wr_acc, rd_acc, in_h, in_v, active, line_end, frame_end;
	logic pix_wr_q;
	logic [23:0] pix_wd_q;
	logic [23:0] pix_q;
	logic valid_q, ls_q, lsh_q, fs_q, fsh_q, cf_q;
	logic [1:0] hs_line, hs_frame;

	// one function for the half-clock width comparison
	function automatic logic [1:0] half_sync(input logic [12:0] w,
		input logic [12:0] pos);
		logic [11:0] full;
		full = w[12:1];
		half_sync[0] = ({1'b0, pos[11:0]} < {1'b0, full});
		half_sync[1] = w[0] && (pos[11:0] == full);
	endfunction

	// both sync outputs share the half-clock decode
	assign hs_line = half_sync(hsw_q, {1'b0, hcnt_q});
	assign hs_frame = half_sync(vsw_q, vsc_q);

	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= 1'b0;
			cpp_q <= `SDT_RST_CPP;
			htot_q <= `SDT_RST_HTOTAL;
			hsw_q <= `SDT_RST_HSW;
			hblk_q <= `SDT_RST_HBLANK;
			hact_q <= `SDT_RST_HACT;
			vtot_q <= `SDT_RST_VTOTAL;
			vsw_q <= `SDT_RST_VSW;
			vblk_q <= `SDT_RST_VBLANK;
			vact_q <= `SDT_RST_VACT;
		end else if (wr_acc) begin
			case (paddr)
			`SDT_ADDR_CTRL: en_q <= pwdata[`SDT_CTRL_EN_BIT];
			`SDT_ADDR_CPP: cpp_q <= (pwdata[3:0] == 4'h0) ? 4'h1 : pwdata[3:0];
			`SDT_ADDR_HTOTAL: htot_q <= pwdata[11:0];
			`SDT_ADDR_HSW: hsw_q <= pwdata[12:0];
			`SDT_ADDR_HBLANK: hblk_q <= pwdata[11:0];
			`SDT_ADDR_HACT: hact_q <= pwdata[11:0];
			`SDT_ADDR_VTOTAL: vtot_q <= pwdata[11:0];
			`SDT_ADDR_VSW: vsw_q <= pwdata[12:0];
			`SDT_ADDR_VBLANK: vblk_q <= pwdata[11:0];
			`SDT_ADDR_VACT: vact_q <= pwdata[11:0];
			default: ;
			endcase
		end
	end

	// pixel words written by software enter the fifo
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pix_wr_q <= 1'b0;
			pix_wd_q <= 24'h000000;
		end else begin
			if (wr_acc && paddr == `SDT_ADDR_PIXEL && !pix_wr_q) begin
				pix_wr_q <= 1'b1;
				pix_wd_q <= pwdata[23:0];
			end else if (fill.ready)
				pix_wr_q <= 1'b0;
		end
	end
	assign fill.valid = pix_wr_q;
	assign fill.data = pix_wd_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (rd_acc) begin
			case (paddr)
			`SDT_ADDR_CTRL: prdata <= {31'h0, en_q};
			`SDT_ADDR_CPP: prdata <= {28'h0, cpp_q};
			`SDT_ADDR_HTOTAL: prdata <= {20'h0, htot_q};
			`SDT_ADDR_HSW: prdata <= {19'h0, hsw_q};
			`SDT_ADDR_HBLANK: prdata <= {20'h0, hblk_q};
			`SDT_ADDR_HACT: prdata <= {20'h0, hact_q};
			`SDT_ADDR_VTOTAL: prdata <= {20'h0, vtot_q};
			`SDT_ADDR_VSW: prdata <= {19'h0, vsw_q};
			`SDT_ADDR_VBLANK: prdata <= {20'h0, vblk_q};
			`SDT_ADDR_VACT: prdata <= {20'h0, vact_q};
			`SDT_ADDR_STATUS: prdata <= {2'h0, f_valid, !fill.ready,
				valid_q, fs_q, vcnt_q, 2'h0, hcnt_q};
			default: prdata <= 32'h00000000;
			endcase
		end
	end

	sdt_fifo #(.WIDTH(`SDT_PIX_W), .DEPTH(`SDT_FIFO_DEPTH)) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.wr(fill),
		.rd_valid(f_valid),
		.rd_data(f_data),
		.rd_ready(f_ready)
	);

	assign line_end = (hcnt_q >= htot_q - 12'h001);
	assign frame_end = (vcnt_q >= vtot_q - 12'h001);
	assign in_h = (hcnt_q >= hblk_q) && (hcnt_q < hblk_q + hact_q);
	assign in_v = (vcnt_q >= vblk_q) && (vcnt_q < vblk_q + vact_q);
	assign active = (state_q == sdt_pkg::SDT_RUN) && in_h && in_v;
	// one fifo word per pixel, popped on its last component
	assign f_ready = active && (comp_q == cpp_q - 4'h1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_q <= sdt_pkg::SDT_IDLE;
		else begin
			case (state_q)
			sdt_pkg::SDT_IDLE:
				if (en_q)
					state_q <= sdt_pkg::SDT_RUN;
			sdt_pkg::SDT_RUN:
				if (!en_q && line_end && frame_end)
					state_q <= sdt_pkg::SDT_IDLE;
			default: state_q <= sdt_pkg::SDT_IDLE;
			endcase
		end
	end

	// line counter wraps at the line total, blanking included
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hcnt_q <= 12'h000;
			vcnt_q <= 12'h000;
		end else if (state_q != sdt_pkg::SDT_RUN) begin
			hcnt_q <= 12'h000;
			vcnt_q <= 12'h000;
		end else if (line_end) begin
			hcnt_q <= 12'h000;
			vcnt_q <= frame_end ? 12'h000 : vcnt_q + 12'h001;
		end else
			hcnt_q <= hcnt_q + 12'h001;
	end

	// component counter inside a pixel period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			comp_q <= 4'h0;
		else if (!active || comp_q >= cpp_q - 4'h1)
			comp_q <= 4'h0;
		else
			comp_q <= comp_q + 4'h1;
	end

	// frame sync position counted in clocks from frame start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			vsc_q <= 13'h0000;
		else if (state_q != sdt_pkg::SDT_RUN || (line_end && frame_end))
			vsc_q <= 13'h0000;
		else if (vsc_q != 13'h1fff)
			vsc_q <= vsc_q + 13'h0001;
	end

	// registered outputs; half flag extends the pulse half a clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ls_q <= 1'b0;
			lsh_q <= 1'b0;
			fs_q <= 1'b0;
			fsh_q <= 1'b0;
			valid_q <= 1'b0;
			pix_q <= 24'h000000;
			cf_q <= 1'b0;
		end else begin
			ls_q <= (state_q == sdt_pkg::SDT_RUN) &&
				hs_line[0];
			lsh_q <= (state_q == sdt_pkg::SDT_RUN) &&
				hs_line[1];
			fs_q <= (state_q == sdt_pkg::SDT_RUN) && (vsc_q[12] == 1'b0) &&
				hs_frame[0];
			fsh_q <= (state_q == sdt_pkg::SDT_RUN) && (vsc_q[12] == 1'b0) &&
				hs_frame[1];
			valid_q <= active;
			pix_q <= active && f_valid ? f_data : 24'h000000;
			cf_q <= active && (comp_q == 4'h0);
		end
	end

	assign line_sync = ls_q;
	assign line_sync_half = lsh_q;
	assign frame_sync = fs_q;
	assign frame_sync_half = fsh_q;
	assign pix_valid = valid_q;
	assign pix_data = pix_q;
	assign pix_comp_first = cf_q;

	a_valid_region: assert property (@(posedge pclk) disable iff (!presetn)
		pix_valid |-> $past(in_h) && $past(in_v))
		else $error("data valid outside active region");
	a_line_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == sdt_pkg::SDT_RUN && line_end) |=> hcnt_q == 12'h000)
		else $error("line counter did not wrap");
	a_lead_hblank: assert property (@(posedge pclk) disable iff (!presetn)
		(hcnt_q < hblk_q) |=> !pix_valid)
		else $error("active data in leading blank");
	a_trail_hblank: assert property (@(posedge pclk) disable iff (!presetn)
		(hcnt_q >= hblk_q + hact_q) |=> !pix_valid)
		else $error("active data in trailing blank");
	a_frame_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == sdt_pkg::SDT_RUN && line_end && frame_end)
		|=> vcnt_q == 12'h000)
		else $error("frame counter did not wrap");
	a_lead_vblank: assert property (@(posedge pclk) disable iff (!presetn)
		(vcnt_q < vblk_q) |=> !pix_valid)
		else $error("active data in leading vertical blank");
	a_trail_vblank: assert property (@(posedge pclk) disable iff (!presetn)
		(vcnt_q >= vblk_q + vact_q) |=> !pix_valid)
		else $error("active data in trailing vertical blank");
	a_comp_bound: assert property (@(posedge pclk) disable iff (!presetn)
		comp_q < cpp_q || comp_q == 4'h0)
		else $error("component count past pixel");
	a_line_sync: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == sdt_pkg::SDT_RUN && hcnt_q == 12'h000 && hsw_q > 13'h0001)
		|=> line_sync)
		else $error("line sync missing at line start");
	a_frame_sync: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(frame_sync) |-> $past(vsc_q) == 13'h0000)
		else $error("frame sync not at frame start");
	// display output checks and the stop check on state_q
	a_half_line: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == sdt_pkg::SDT_RUN && hsw_q[0] && hcnt_q == hsw_q[12:1])
		|=> line_sync_half)
		else $error("line sync half step missing");
	a_half_frame: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == sdt_pkg::SDT_RUN && vsw_q[0] &&
		vsc_q == {1'b0, vsw_q[12:1]}) |=> frame_sync_half)
		else $error("frame sync half step missing");
	a_half_excl: assert property (@(posedge pclk) disable iff (!presetn)
		!(line_sync && line_sync_half))
		else $error("line sync and half step overlap");
	a_pix_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!pix_valid |-> pix_data == 24'h000000)
		else $error("pixel data outside active region");
	a_comp_first: assert property (@(posedge pclk) disable iff (!presetn)
		pix_comp_first |-> pix_valid)
		else $error("component marker outside active region");
	a_sync_idle: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q != sdt_pkg::SDT_RUN) |=> !line_sync && !frame_sync)
		else $error("sync pulse while stopped");
	a_run_stop: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == sdt_pkg::SDT_RUN && !en_q && line_end && frame_end)
		|=> state_q == sdt_pkg::SDT_IDLE)
		else $error("generator did not stop at frame end");
	c_run: cover property (@(posedge pclk) $rose(state_q == sdt_pkg::SDT_RUN));
	c_pixel: cover property (@(posedge pclk) pix_valid && pix_data != 24'h0);
	c_frame: cover property (@(posedge pclk) $rose(frame_sync));
	c_half: cover property (@(posedge pclk) line_sync_half);
	c_fhalf: cover property (@(posedge pclk) frame_sync_half);
endmodule // sdt_timing

// ### test/sdt_panel_model.sv
// panel model that measures the timing it receives
`timescale 1ns/1ps
module sdt_panel_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// display side
	input wire logic line_sync,
	input wire logic line_sync_half,
	input wire logic frame_sync,
	input wire logic frame_sync_half,
	input wire logic pix_valid,
	input wire logic [23:0] pix_data,
	input wire logic pix_comp_first
);
	int cyc, tl, tf, lp, fp, hw, hh, vw, vh, aw, al, nc, vl, vo, bad;
	int c_hw, c_hh, c_vw, c_vh, c_aw, c_nc, c_vl;
	logic [23:0] got[$];
	logic ls_q, fs_q, pv_q;
	always @(posedge pclk) begin
		cyc++;
		if (line_sync && !ls_q) begin
			lp = cyc - tl;
			tl = cyc;
			hw = c_hw;
			hh = c_hh;
			if (c_aw > 0) begin
				aw = c_aw;
				nc = c_nc;
			end
			c_hw = 0;
			c_hh = 0;
			c_aw = 0;
			c_nc = 0;
		end
		if (frame_sync && !fs_q) begin
			fp = cyc - tf;
			tf = cyc;
			vw = c_vw;
			vh = c_vh;
			vl = c_vl;
			c_vw = 0;
			c_vh = 0;
			c_vl = 0;
		end
		if (pix_valid && !pv_q) begin
			al = cyc - tl;
			if (c_vl == 0)
				vo = cyc - tf;
			c_vl++;
		end
		c_hw += int'(line_sync);
		c_hh += int'(line_sync_half);
		c_vw += int'(frame_sync);
		c_vh += int'(frame_sync_half);
		c_aw += int'(pix_valid);
		c_nc += int'(pix_valid && pix_comp_first);
		if (pix_valid && pix_comp_first)
			got.push_back(pix_data);
		if (pix_valid !== 1'b1 && pix_data !== 24'h000000)
			bad++;
		ls_q = line_sync;
		fs_q = frame_sync;
		pv_q = pix_valid;
	end
endmodule // sdt_panel_model

// ### test/test_sdt_timing.sv
// self-checking bench for the display frame timing generator
`timescale 1ns/1ps
`include "sdt_cfg.svh"
module test_sdt_timing;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic er;
	logic ls, lsh, fs, fsh, pv, pcf;
	logic [23:0] pd;
	logic [31:0] rv[9];
	int n_fail, compares;
	int cfg[9] = '{2, 12, 5, 3, 4, 5, 3, 1, 2};
	sdt_timing u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .line_sync(ls), .line_sync_half(lsh),
		.frame_sync(fs), .frame_sync_half(fsh), .pix_valid(pv),
		.pix_data(pd), .pix_comp_first(pcf));
	sdt_panel_model u_pan (.pclk(pclk), .presetn(presetn),
		.line_sync(ls), .line_sync_half(lsh), .frame_sync(fs),
		.frame_sync_half(fsh), .pix_valid(pv), .pix_data(pd),
		.pix_comp_first(pcf));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic conclude();
		if (n_fail == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; read data lands in rd
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	initial begin
		repeat (5000) @(posedge pclk);
		n_fail++;
		conclude();
	end
	initial begin
		rv = '{32'(`SDT_RST_CPP), 32'(`SDT_RST_HTOTAL), 32'(`SDT_RST_HSW),
			32'(`SDT_RST_HBLANK), 32'(`SDT_RST_HACT), 32'(`SDT_RST_VTOTAL),
			32'(`SDT_RST_VSW), 32'(`SDT_RST_VBLANK), 32'(`SDT_RST_VACT)};
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'b000;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			apb(1'b0, 12'(4 * i + 4), 32'h0);
			check(rd, rv[i]);
		end
		apb(1'b1, 12'h030, 32'h0000_00ff);
		apb(1'b0, 12'h030, 32'h0);
		check(rd, 32'h00000000);
		check({31'h0, er}, 32'h0);
		for (int i = 0; i < 9; i++) begin
			apb(1'b1, 12'(4 * i + 4), 32'(cfg[i]));
			apb(1'b0, 12'(4 * i + 4), 32'h0);
			check(rd, 32'(cfg[i]));
		end
		for (int k = 0; k < 16; k++)
			apb(1'b1, `SDT_ADDR_PIXEL, 32'h00c0_0000 + 32'(k));
		apb(1'b0, `SDT_ADDR_STATUS, 32'h0);
		check({30'h0, rd[29:28]}, 32'h3);
		apb(1'b1, `SDT_ADDR_CTRL, 32'h1);
		repeat (200) @(posedge pclk);
		check(u_pan.lp, 12);
		check(u_pan.fp, 60);
		check(u_pan.hw, 2);
		check(u_pan.hh, 1);
		check(u_pan.vw, 1);
		check(u_pan.vh, 1);
		check(u_pan.aw, 4);
		check(u_pan.al, 3);
		check(u_pan.nc, 2);
		check(u_pan.vl, 2);
		check(u_pan.vo, 15);
		check(u_pan.bad, 0);
		for (int k = 0; k < 8; k++)
			check(u_pan.got[k], 32'h00c0_0000 + 32'(k));
		repeat (100) @(posedge pclk);
		apb(1'b0, `SDT_ADDR_STATUS, 32'h0);
		check({30'h0, rd[29:28]}, 32'h0);
		// clearing enable stops the counters at the next frame end
		apb(1'b1, `SDT_ADDR_CTRL, 32'h0);
		repeat (70) @(posedge pclk);
		apb(1'b0, `SDT_ADDR_STATUS, 32'h0);
		check(rd, 32'h00000000);
		conclude();
	end
endmodule // test_sdt_timing
